// ===== verif/dbu_far_model.sv
// Far-side model: transmit shifter and receive sampler of the serial port.
`timescale 1ns/1ps
`default_nettype none
module dbu_far_model (
    // Clock.
    input  wire logic       clk_in,
    // Transmit shifter side.
    input  wire logic       valid_in,
    output logic            take_out,
    output logic            busy_out,
    output logic            serial_out,
    // Receive sampler side.
    output logic      [7:0] char_out,
    output logic            strobe_out,
    output logic            ferr_out,
    output logic            perr_out
);
    int stall = 0;    // Cycles a held character waits before the shifter takes it.
    int wait_cnt = 0; // Cycles waited so far.
    int busy_cnt = 0; // Bit times left in the frame.
    initial begin
        take_out = 1'b0;
        char_out = 8'h00;
        strobe_out = 1'b0;
        ferr_out = 1'b0;
        perr_out = 1'b0;
    end
    // The line toggles within a frame so a stale value never looks idle.
    assign busy_out = (busy_cnt != 0);
    assign serial_out = (busy_cnt == 0) | busy_cnt[0];
    // Take a held character only once the previous frame is over.
    always @(posedge clk_in) begin
        take_out <= 1'b0;
        if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
        if (valid_in && !take_out && busy_cnt == 0) begin
            if (wait_cnt < stall) wait_cnt <= wait_cnt + 1;
            else begin
                take_out <= 1'b1;
                busy_cnt <= 4;
                wait_cnt <= 0;
            end
        end
    end
    // One received character with its error pulses, then the bus shows junk.
    task automatic send_char(input logic [7:0] c, input logic fe, input logic pe);
        @(posedge clk_in);
        char_out <= c;
        strobe_out <= 1'b1;
        ferr_out <= fe;
        perr_out <= pe;
        @(posedge clk_in);
        char_out <= ~c;
        strobe_out <= 1'b0;
        ferr_out <= 1'b0;
        perr_out <= 1'b0;
    endtask : send_char
endmodule : dbu_far_model
`default_nettype wire

// ===== verif/debug_uart_regs_tb_top.sv
// Self-checking bench for the debug serial port register block.
`timescale 1ns/1ps
`default_nettype none
module debug_uart_regs_tb_top import dbu_pkg::*;;
    logic clk_in = 1'b0, reset_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
    logic pwrite_in = 1'b0, rxd_in = 1'b1, pready_out, pslverr_out, rd_e;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h00000000, prdata_out, rd_v;
    logic [7:0] tx_char_out, rx_char_in;
    logic [2:0] parity_select_out;
    logic [3:0] dma_in = 4'h0;
    logic [1:0] dcc_in = 2'h0;
    logic tx_char_valid_out, tx_take_in, tx_busy_in, tx_serial_in, rx_char_strobe_in;
    logic rx_frame_err_in, rx_parity_err_in, rx_serial_out, parity_used_out;
    logic rx_enable_out, tx_enable_out, txd_out, irq_out;
    logic [31:0] ch_exp [4] = '{32'h2, 32'h0, 32'h3, 32'h1}; // Expected {txd, rx line}.
    int n_errors = 0, total_checks = 0;
    always #5 clk_in = ~clk_in;
    dbu_regs uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .tx_char_out(tx_char_out),
        .tx_char_valid_out(tx_char_valid_out), .tx_take_in(tx_take_in),
        .tx_busy_in(tx_busy_in), .tx_serial_in(tx_serial_in), .rx_char_in(rx_char_in),
        .rx_char_strobe_in(rx_char_strobe_in), .rx_frame_err_in(rx_frame_err_in),
        .rx_parity_err_in(rx_parity_err_in), .rx_serial_out(rx_serial_out),
        .parity_select_out(parity_select_out), .parity_used_out(parity_used_out),
        .rx_enable_out(rx_enable_out), .tx_enable_out(tx_enable_out),
        .rx_dma_done_in(dma_in[0]), .tx_dma_done_in(dma_in[1]),
        .tx_dma_buffer_drained_in(dma_in[2]), .rx_dma_buffer_filled_in(dma_in[3]),
        .dcc_write_pending_in(dcc_in[0]), .dcc_read_pending_in(dcc_in[1]),
        .rxd_in(rxd_in), .txd_out(txd_out), .irq_out(irq_out));
    dbu_far_model far (.clk_in(clk_in), .valid_in(tx_char_valid_out), .take_out(tx_take_in),
        .busy_out(tx_busy_in), .serial_out(tx_serial_in), .char_out(rx_char_in),
        .strobe_out(rx_char_strobe_in), .ferr_out(rx_frame_err_in),
        .perr_out(rx_parity_err_in));
    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // One APB transfer; the request stands until pready is seen at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (pready_out !== 1'b1) begin
            n_errors++;
            finish_test();
        end
        rd_v = prdata_out;
        rd_e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (2) @(posedge clk_in);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        check(rd_v & m, e);
    endtask : rd
    initial begin
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rd(DBU_OFS_MODE, 32'hFFFFFFFF, 32'h00000000);
        rd(DBU_OFS_STATUS, 32'hFFFFFFFF, 32'h00000000);
        rd(12'h020, 32'hFFFFFFFF, 32'h00000000);
        check({31'h0, rd_e}, 32'h00000001);
        wr(DBU_OFS_MODE, 32'hFFFFFFFF);
        rd(DBU_OFS_MODE, 32'hFFFFFFFF, 32'h0000CE00);
        for (int p = 0; p < 8; p++) begin
            wr(DBU_OFS_MODE, p << DBU_MR_PTY_LO);
            check({28'h0, parity_used_out, parity_select_out}, {28'h0, p < 4, 3'(p)});
        end
        rxd_in <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            wr(DBU_OFS_MODE, c << DBU_MR_CH_LO);
            repeat (4) @(posedge clk_in);
            check({30'h0, txd_out, rx_serial_out}, ch_exp[c]);
        end
        rxd_in <= 1'b1;
        wr(DBU_OFS_MODE, 32'h00000000);
        $display("mode test done");
        wr(DBU_OFS_IEN, 32'hFFFFFFFF);
        rd(DBU_OFS_IMASK, 32'hFFFFFFFF, DBU_IRQ_VALID);
        wr(DBU_OFS_IDIS, 32'h0000000F);
        rd(DBU_OFS_IMASK, 32'hFFFFFFFF, 32'hC0001AF0);
        wr(DBU_OFS_IEN, 32'h00000000);
        rd(DBU_OFS_IMASK, 32'hFFFFFFFF, 32'hC0001AF0);
        wr(DBU_OFS_IDIS, 32'hFFFFFFFF);
        rd(DBU_OFS_IMASK, 32'hFFFFFFFF, 32'h00000000);
        $display("mask test done");
        wr(DBU_OFS_CTRL, 32'h00000050);
        rd(DBU_OFS_STATUS, 32'h00000203, 32'h00000202);
        check({30'h0, rx_enable_out, tx_enable_out}, 32'h00000003);
        far.stall = 20;
        wr(DBU_OFS_TXHOLD, 32'h000001A5);
        rd(DBU_OFS_STATUS, 32'h00000202, 32'h00000000);
        check({24'h0, tx_char_out}, 32'h000000A5);
        repeat (40) @(posedge clk_in);
        rd(DBU_OFS_STATUS, 32'h00000202, 32'h00000202);
        $display("transmit test done");
        far.send_char(8'h3C, 1'b0, 1'b0);
        rd(DBU_OFS_STATUS, 32'h000000E1, 32'h00000001);
        rd(DBU_OFS_RXHOLD, 32'hFFFFFFFF, 32'h0000003C);
        rd(DBU_OFS_STATUS, 32'h00000001, 32'h00000000);
        far.send_char(8'h11, 1'b1, 1'b0);
        far.send_char(8'hC3, 1'b0, 1'b1);
        rd(DBU_OFS_STATUS, 32'h000000E1, 32'h000000E1);
        rd(DBU_OFS_RXHOLD, 32'hFFFFFFFF, 32'h000000C3);
        rd(DBU_OFS_STATUS, 32'h000000E1, 32'h000000E0);
        wr(DBU_OFS_CTRL, 32'h00000100);
        rd(DBU_OFS_STATUS, 32'h000000E1, 32'h00000000);
        $display("receive test done");
        dma_in <= 4'h5;
        dcc_in <= 2'h1;
        repeat (4) @(posedge clk_in);
        rd(DBU_OFS_STATUS, 32'hC0001818, 32'h40000808);
        wr(DBU_OFS_IEN, 32'h00000008);
        check({31'h0, irq_out}, 32'h00000001);
        wr(DBU_OFS_IDIS, 32'h00000008);
        check({31'h0, irq_out}, 32'h00000000);
        $display("flag test done");
        finish_test();
    end
endmodule : debug_uart_regs_tb_top
`default_nettype wire

// ===== verilog/dbu_pkg.sv
// Shared constants of the debug serial port register block.
package dbu_pkg;
    // Register byte offsets on the APB.
    localparam logic [11:0] DBU_OFS_CTRL   = 12'h000;
    localparam logic [11:0] DBU_OFS_MODE   = 12'h004;
    localparam logic [11:0] DBU_OFS_IEN    = 12'h008;
    localparam logic [11:0] DBU_OFS_IDIS   = 12'h00C;
    localparam logic [11:0] DBU_OFS_IMASK  = 12'h010;
    localparam logic [11:0] DBU_OFS_STATUS = 12'h014;
    localparam logic [11:0] DBU_OFS_RXHOLD = 12'h018;
    localparam logic [11:0] DBU_OFS_TXHOLD = 12'h01C;
    // Control register command bits.
    localparam int unsigned DBU_CR_RXEN   = 4;
    localparam int unsigned DBU_CR_RXDIS  = 5;
    localparam int unsigned DBU_CR_TXEN   = 6;
    localparam int unsigned DBU_CR_TXDIS  = 7;
    localparam int unsigned DBU_CR_CLRERR = 8;
    // Mode register fields.
    localparam int unsigned DBU_MR_PTY_LO = 9;
    localparam int unsigned DBU_MR_PTY_HI = 11;
    localparam int unsigned DBU_MR_CH_LO  = 14;
    localparam int unsigned DBU_MR_CH_HI  = 15;
    // Status, enable, disable and mask bit positions.
    localparam int unsigned DBU_ST_RXAV    = 0;
    localparam int unsigned DBU_ST_TXFREE  = 1;
    localparam int unsigned DBU_ST_RXDMA   = 3;
    localparam int unsigned DBU_ST_TXDMA   = 4;
    localparam int unsigned DBU_ST_OVR     = 5;
    localparam int unsigned DBU_ST_FRM     = 6;
    localparam int unsigned DBU_ST_PTY     = 7;
    localparam int unsigned DBU_ST_TXIDLE  = 9;
    localparam int unsigned DBU_ST_TXDRN   = 11;
    localparam int unsigned DBU_ST_RXFUL   = 12;
    localparam int unsigned DBU_ST_DCCWR   = 30;
    localparam int unsigned DBU_ST_DCCRD   = 31;
    // Bits that exist in the mask register.
    localparam logic [31:0] DBU_IRQ_VALID = 32'hC0001AFB;
    // Character width.
    localparam int unsigned DBU_CHAR_W = 8;
    // Channel modes.
    localparam logic [1:0] DBU_CH_NORMAL = 2'h0;
    localparam logic [1:0] DBU_CH_ECHO   = 2'h1;
    localparam logic [1:0] DBU_CH_LOCAL  = 2'h2;
    localparam logic [1:0] DBU_CH_REMOTE = 2'h3;
    // Reset values.
    localparam logic [31:0] DBU_ZERO32 = 32'h00000000;
    localparam logic [2:0]  DBU_PAR_RST = 3'h0;
    localparam logic [1:0]  DBU_CH_RST  = 2'h0;
    localparam logic [7:0]  DBU_CHAR_RST = 8'h00;
endpackage : dbu_pkg

// ===== verilog/dbu_regs.sv
// Register block of the debug serial port with APB slave and channel muxing.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Mode holds parity 11:9, channel mode 15:14
// - Parity codes even, odd, zero, one, none
// - Enable write of one sets mask bit
// - Disable write of one clears mask bit
// - Mask read shows enabled sources
// - All flag registers share one bit layout
// - Receive ready set on char, cleared by read
// - Transmit ready low while holding char waits
// - DMA end flags follow DMA channel signals
// - Buffer empty and full follow DMA signals
// - Overrun, framing, parity errors are sticky
// - Transmitter empty only when fully idle, enabled
// - Debug channel flags mirror processor levels
// - Receive holding returns last char bits 7:0
// - Status reset command clears error flags
// - Local loopback: internal feed, pin held high
module dbu_regs
    import dbu_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    // APB slave.
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Transmit shifter side.
    output logic      [7:0]  tx_char_out,
    output logic             tx_char_valid_out,
    input  wire logic        tx_take_in,
    input  wire logic        tx_busy_in,
    input  wire logic        tx_serial_in,
    // Receive sampler side.
    input  wire logic [7:0]  rx_char_in,
    input  wire logic        rx_char_strobe_in,
    input  wire logic        rx_frame_err_in,
    input  wire logic        rx_parity_err_in,
    output logic             rx_serial_out,
    // Line settings to the shifters.
    output logic      [2:0]  parity_select_out,
    output logic             parity_used_out,
    output logic             rx_enable_out,
    output logic             tx_enable_out,
    // Peripheral DMA channel signals.
    input  wire logic        rx_dma_done_in,
    input  wire logic        tx_dma_done_in,
    input  wire logic        tx_dma_buffer_drained_in,
    input  wire logic        rx_dma_buffer_filled_in,
    // Processor debug channel levels.
    input  wire logic        dcc_write_pending_in,
    input  wire logic        dcc_read_pending_in,
    // Serial pins.
    input  wire logic        rxd_in,
    output logic             txd_out,
    // Interrupt request.
    output logic             irq_out
);
    logic        rst_meta_r;        // Reset release stage one.
    logic        rst_n_r;           // Reset used by the rest of the block.
    logic        pready_r;          // Access phase answer.
    logic        acc_ok;            // Transfer completes on this edge.
    logic        wr_acc;            // Completing write.
    logic        rd_acc;            // Completing read.
    logic [2:0]  parity_select_r;   // Parity selector.
    logic [1:0]  channel_loop_select_r; // Channel mode.
    logic [31:0] irq_mask_r;        // Enabled interrupt sources.
    logic        rx_en_r;           // Receiver enabled.
    logic        tx_en_r;           // Transmitter enabled.
    logic        rx_char_available_r; // Receive holding full.
    logic [7:0]  received_char_r;   // Receive holding register.
    logic        tx_hold_full_r;    // Transmit holding register occupied.
    logic [7:0]  char_to_send_r;    // Transmit holding register.
    logic        overrun_set;       // Character arrived over an unread one.
    logic        clear_error_flags; // Status reset command this edge.
    logic        overrun_flag;      // Sticky overrun.
    logic        frame_error_flag;  // Sticky framing error.
    logic        parity_error_flag; // Sticky parity error.
    logic        rxd_s;             // Synchronised receive pin.
    logic [1:0]  dcc_s;             // Synchronised debug channel levels.
    logic        rx_live;           // Receiver enabled and not in remote loop.
    logic        tx_live;           // Transmitter enabled and not in remote loop.
    logic [31:0] line_status;       // Assembled status word.
    logic [31:0] rd_data;           // Read mux output.
    logic        rd_err;            // Unmapped address.

    // Reset is asserted at once and released through two flops.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // Pin and processor levels come from other domains.
    dbu_sync2 #(.W(1), .RST_VAL(1'b1)) u_rxd_sync (
        .clk_in     (clk_in),
        .reset_n_in (rst_n_r),
        .async_in   (rxd_in),
        .sync_out   (rxd_s)
    );
    dbu_sync2 #(.W(2), .RST_VAL(2'h0)) u_dcc_sync (
        .clk_in     (clk_in),
        .reset_n_in (rst_n_r),
        .async_in   ({dcc_read_pending_in, dcc_write_pending_in}),
        .sync_out   (dcc_s)
    );

    // One wait state lets read data come straight from a flop.
    assign acc_ok = psel_in & penable_in & pready_r;
    assign wr_acc = acc_ok & pwrite_in;
    assign rd_acc = acc_ok & ~pwrite_in;
    assign clear_error_flags = wr_acc && (paddr_in == DBU_OFS_CTRL) &&
                               pwdata_in[DBU_CR_CLRERR];
    // Remote loopback disables both shifters.
    assign rx_live = rx_en_r & (channel_loop_select_r != DBU_CH_REMOTE);
    assign tx_live = tx_en_r & (channel_loop_select_r != DBU_CH_REMOTE);

    // APB answer timing: ready rises on the second access cycle.
    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pready_r    <= 1'b0;
            prdata_out  <= DBU_ZERO32;
            pslverr_out <= 1'b0;
        end else begin
            pready_r    <= psel_in & penable_in & ~pready_r;
            prdata_out  <= (psel_in & penable_in & ~pready_r & ~pwrite_in) ? rd_data
                                                                           : DBU_ZERO32;
            pslverr_out <= psel_in & penable_in & ~pready_r & rd_err;
        end
    end
    assign pready_out = pready_r;

    // Mode register; no decoding here, the shifters use the fields.
    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            parity_select_r       <= DBU_PAR_RST;
            channel_loop_select_r <= DBU_CH_RST;
        end else if (wr_acc && paddr_in == DBU_OFS_MODE) begin
            parity_select_r       <= pwdata_in[DBU_MR_PTY_HI:DBU_MR_PTY_LO];
            channel_loop_select_r <= pwdata_in[DBU_MR_CH_HI:DBU_MR_CH_LO];
        end
    end

    // Enable and disable writes act only on the bits written as one.
    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            irq_mask_r <= DBU_ZERO32;
        end else if (wr_acc && paddr_in == DBU_OFS_IEN) begin
            irq_mask_r <= irq_mask_r | (pwdata_in & DBU_IRQ_VALID);
        end else if (wr_acc && paddr_in == DBU_OFS_IDIS) begin
            irq_mask_r <= irq_mask_r & ~pwdata_in;
        end
    end

    // Control commands; disable wins over enable when both are written.
    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rx_en_r <= 1'b0;
            tx_en_r <= 1'b0;
        end else if (wr_acc && paddr_in == DBU_OFS_CTRL) begin
            if (pwdata_in[DBU_CR_RXDIS]) begin
                rx_en_r <= 1'b0;
            end else if (pwdata_in[DBU_CR_RXEN]) begin
                rx_en_r <= 1'b1;
            end
            if (pwdata_in[DBU_CR_TXDIS]) begin
                tx_en_r <= 1'b0;
            end else if (pwdata_in[DBU_CR_TXEN]) begin
                tx_en_r <= 1'b1;
            end
        end
    end

    // Receive holding: an arriving character beats a same-cycle read.
    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rx_char_available_r <= 1'b0;
            received_char_r     <= DBU_CHAR_RST;
        end else if (!rx_live) begin
            rx_char_available_r <= 1'b0;
        end else if (rx_char_strobe_in) begin
            rx_char_available_r <= 1'b1;
            received_char_r     <= rx_char_in;
        end else if (rd_acc && paddr_in == DBU_OFS_RXHOLD) begin
            rx_char_available_r <= 1'b0;
        end
    end
    // A new character over one nobody has read is an overrun.
    assign overrun_set = rx_live & rx_char_strobe_in & rx_char_available_r &
                         ~(rd_acc && paddr_in == DBU_OFS_RXHOLD);

    // Transmit holding; a write while full overwrites, so software must wait.
    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            tx_hold_full_r <= 1'b0;
            char_to_send_r <= DBU_CHAR_RST;
        end else if (!tx_live) begin
            tx_hold_full_r <= 1'b0;
        end else if (wr_acc && paddr_in == DBU_OFS_TXHOLD) begin
            tx_hold_full_r <= 1'b1;
            char_to_send_r <= pwdata_in[DBU_CHAR_W-1:0];
        end else if (tx_take_in) begin
            tx_hold_full_r <= 1'b0;
        end
    end
    assign tx_char_out       = char_to_send_r;
    assign tx_char_valid_out = tx_hold_full_r;

    // Sticky error flags.
    dbu_sticky u_ovr (
        .clk_in     (clk_in),
        .reset_n_in (rst_n_r),
        .set_in     (overrun_set),
        .clear_in   (clear_error_flags),
        .flag_out   (overrun_flag)
    );
    dbu_sticky u_frm (
        .clk_in     (clk_in),
        .reset_n_in (rst_n_r),
        .set_in     (rx_live & rx_frame_err_in),
        .clear_in   (clear_error_flags),
        .flag_out   (frame_error_flag)
    );
    dbu_sticky u_pty (
        .clk_in     (clk_in),
        .reset_n_in (rst_n_r),
        .set_in     (rx_live & rx_parity_err_in & parity_used_out),
        .clear_in   (clear_error_flags),
        .flag_out   (parity_error_flag)
    );

    // Status word assembled in the shared layout.
    always_comb begin
        line_status                = DBU_ZERO32;
        line_status[DBU_ST_RXAV]   = rx_char_available_r;
        line_status[DBU_ST_TXFREE] = tx_live & ~tx_hold_full_r;
        line_status[DBU_ST_RXDMA]  = rx_dma_done_in;
        line_status[DBU_ST_TXDMA]  = tx_dma_done_in;
        line_status[DBU_ST_OVR]    = overrun_flag;
        line_status[DBU_ST_FRM]    = frame_error_flag;
        line_status[DBU_ST_PTY]    = parity_error_flag;
        line_status[DBU_ST_TXIDLE] = tx_live & ~tx_hold_full_r & ~tx_busy_in;
        line_status[DBU_ST_TXDRN]  = tx_dma_buffer_drained_in;
        line_status[DBU_ST_RXFUL]  = rx_dma_buffer_filled_in;
        line_status[DBU_ST_DCCWR]  = dcc_s[0];
        line_status[DBU_ST_DCCRD]  = dcc_s[1];
    end

    // Read mux; write-only registers read zero, other addresses give an error.
    always_comb begin
        rd_data = DBU_ZERO32;
        rd_err  = 1'b0;
        case (paddr_in)
            DBU_OFS_MODE: begin
                rd_data[DBU_MR_PTY_HI:DBU_MR_PTY_LO] = parity_select_r;
                rd_data[DBU_MR_CH_HI:DBU_MR_CH_LO]   = channel_loop_select_r;
            end
            DBU_OFS_IMASK:  rd_data = irq_mask_r;
            DBU_OFS_STATUS: rd_data = line_status;
            DBU_OFS_RXHOLD: rd_data[DBU_CHAR_W-1:0] = received_char_r;
            DBU_OFS_CTRL, DBU_OFS_IEN, DBU_OFS_IDIS, DBU_OFS_TXHOLD: rd_data = DBU_ZERO32;
            default:        rd_err = 1'b1;
        endcase
    end

    // Line settings and interrupt, all registered.
    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            parity_select_out <= DBU_PAR_RST;
            parity_used_out   <= 1'b0;
            rx_enable_out     <= 1'b0;
            tx_enable_out     <= 1'b0;
            irq_out           <= 1'b0;
        end else begin
            parity_select_out <= parity_select_r;
            parity_used_out   <= ~parity_select_r[DBU_MR_PTY_HI-DBU_MR_PTY_LO];
            rx_enable_out     <= rx_live;
            tx_enable_out     <= tx_live;
            irq_out           <= |(line_status & irq_mask_r);
        end
    end

    // Channel routing between pins and shifters; idle line is high.
    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            txd_out       <= 1'b1;
            rx_serial_out <= 1'b1;
        end else begin
            case (channel_loop_select_r)
                DBU_CH_NORMAL: begin
                    txd_out       <= tx_serial_in;
                    rx_serial_out <= rxd_s;
                end
                DBU_CH_ECHO: begin
                    txd_out       <= rxd_s;
                    rx_serial_out <= rxd_s;
                end
                DBU_CH_LOCAL: begin
                    txd_out       <= 1'b1;
                    rx_serial_out <= tx_serial_in;
                end
                default: begin
                    txd_out       <= rxd_s;
                    rx_serial_out <= 1'b1;
                end
            endcase
        end
    end

    // Checks on the register behaviour.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_r);

    mask_set_a: assert property (wr_acc && paddr_in == DBU_OFS_IEN |=>
        ((irq_mask_r & $past(pwdata_in) & DBU_IRQ_VALID) == ($past(pwdata_in) & DBU_IRQ_VALID)))
        else $error("enable write did not set mask bits");
    mask_clear_a: assert property (wr_acc && paddr_in == DBU_OFS_IDIS |=>
        ((irq_mask_r & $past(pwdata_in)) == DBU_ZERO32)
        && ((irq_mask_r | $past(pwdata_in)) == ($past(irq_mask_r) | $past(pwdata_in))))
        else $error("disable write changed wrong mask bits");
    rx_ready_set_a: assert property (rx_live && rx_char_strobe_in |=>
        rx_char_available_r && received_char_r == $past(rx_char_in))
        else $error("received character not held");
    rx_read_clear_a: assert property (rd_acc && paddr_in == DBU_OFS_RXHOLD
        && !rx_char_strobe_in |=> !rx_char_available_r)
        else $error("receive ready not cleared by read");
    overrun_sticky_a: assert property (overrun_flag && !clear_error_flags |=>
        overrun_flag)
        else $error("overrun flag dropped without clear");
    error_clear_a: assert property (clear_error_flags && !rx_parity_err_in
        && !rx_frame_err_in |=> !parity_error_flag && !frame_error_flag)
        else $error("status reset did not clear errors");
    irq_follow_a: assert property (##1
        irq_out == |($past(line_status) & $past(irq_mask_r)))
        else $error("interrupt output wrong");
    tx_idle_a: assert property (!tx_live |-> !line_status[DBU_ST_TXIDLE]
        && !line_status[DBU_ST_TXFREE])
        else $error("transmitter flags high while disabled");
    local_loop_a: assert property (channel_loop_select_r == DBU_CH_LOCAL |=>
        txd_out && rx_serial_out == $past(tx_serial_in))
        else $error("local loopback routing wrong");
    apb_answer_a: assert property (psel_in && penable_in && !pready_r |=> pready_r)
        else $error("apb answer late");

    rx_read_c: cover property (rx_char_available_r ##[1:20] rd_acc && paddr_in == DBU_OFS_RXHOLD);
    overrun_c: cover property (overrun_set);
    tx_send_c: cover property (tx_hold_full_r ##[1:20] tx_take_in);
    irq_c:     cover property (irq_out);
endmodule : dbu_regs
`default_nettype wire

// ===== verilog/dbu_sticky.sv
// Sticky error flag: set by hardware, cleared by software, set wins.
`timescale 1ns/1ps
`default_nettype none
module dbu_sticky (
    // Clock and reset.
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    // Event and clear command.
    input  wire logic set_in,
    input  wire logic clear_in,
    output logic      flag_out
);
    // An error seen in the clearing cycle must not be lost, so set has priority.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flag_out <= 1'b0;
        end else if (set_in) begin
            flag_out <= 1'b1;
        end else if (clear_in) begin
            flag_out <= 1'b0;
        end
    end
endmodule : dbu_sticky
`default_nettype wire

// ===== verilog/dbu_sync2.sv
// Two-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module dbu_sync2 #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input  wire logic         clk_in,
    input  wire logic         reset_n_in,
    // Asynchronous level in, synchronised level out.
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r; // First stage, read only by the second stage.

    // Both stages reset to the idle value so nothing glitches after reset.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_r   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : dbu_sync2
`default_nettype wire
